// ---- shared/pdt_pkg.sv ----
// Summary of operation
// - The two-bit retry field asks for zero to three automatic resends.
// - Frame-kind codes 000b to 100b send a message on one of the five packet start types.
// - Frame-kind 101b sends Hard Reset, 110b Cable Reset, 111b the BIST carrier pattern.
// - The transmit length register returns to zero when an attempt ends, good or bad.
// - Header bits 7:0 sit at 0x52 and bits 15:8 at 0x53, both resetting to zero.
// - Payload bytes live at 0x54 to 0x6F, seven 32-bit objects, resetting to zero.
// - The bus voltage reads as ten bits of 25 mV, low byte first, top bits in 1:0 next.
// - Bits 3:2 of the upper voltage byte give the divisor code, 11 reserved.
// - A send requested while the received-message flag is set is dropped unsent.
// - Transmit control returns to zero when an attempt ends, good or bad.
`default_nettype none
package pdt_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TX_CTRL   = 8'h50;
    localparam logic [7:0] OFS_TX_LEN    = 8'h51;
    localparam logic [7:0] OFS_HDR_LOW   = 8'h52;
    localparam logic [7:0] OFS_HDR_HIGH  = 8'h53;
    localparam logic [7:0] OFS_PAY_FIRST = 8'h54;
    localparam logic [7:0] OFS_PAY_LAST  = 8'h6F;
    localparam logic [7:0] OFS_VOLT_LOW  = 8'h70;
    localparam logic [7:0] OFS_VOLT_HIGH = 8'h71;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int         PAY_BYTES     = 28;
    localparam int         RETRY_LSB     = 4;
    localparam int         KIND_LSB      = 0;
    localparam logic [7:0] CTRL_WR_MASK  = 8'hF7;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [9:0] RST_VOLT      = 10'h000;
    localparam logic [1:0] RST_SCALE     = 2'h0;
    typedef enum logic [2:0] {
        PDT_KIND_SOP      = 3'b000,
        PDT_KIND_SOP_P    = 3'b001,
        PDT_KIND_SOP_PP   = 3'b010,
        PDT_KIND_DBG_P    = 3'b011,
        PDT_KIND_DBG_PP   = 3'b100,
        PDT_KIND_HARD_RST = 3'b101,
        PDT_KIND_CABLE_RST= 3'b110,
        PDT_KIND_BIST     = 3'b111
    } pdt_kind_t;
    typedef enum logic [0:0] {
        PDT_IDLE = 1'b0,
        PDT_BUSY = 1'b1
    } pdt_state_t;
endpackage : pdt_pkg
`default_nettype wire

// ---- logic/pdt_tx_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
module pdt_tx_regs (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_b,
    input  wire logic                 i_reg_wr,
    input  wire logic                 i_reg_rd,
    input  wire logic [7:0]           i_reg_addr,
    input  wire logic [7:0]           i_reg_wdata,
    output logic      [7:0]           o_reg_rdata,
    input  wire logic                 i_received_message_flag,
    input  wire logic                 i_tx_done,
    input  wire logic [4:0]           i_tx_byte_idx,
    input  wire logic [9:0]           i_bus_voltage_reading,
    input  wire logic [1:0]           i_scale_code,
    output logic                      o_tx_start,
    output logic                      o_tx_discard,
    output logic                      o_tx_busy,
    output pdt_pkg::pdt_kind_t        o_tx_frame_kind,
    output logic                      o_tx_is_message,
    output logic                      o_tx_is_ordered_set,
    output logic                      o_tx_is_bist,
    output logic      [1:0]           o_tx_retries,
    output logic      [7:0]           o_tx_length,
    output logic      [7:0]           o_tx_header_low,
    output logic      [7:0]           o_tx_header_high,
    output logic      [7:0]           o_tx_payload_byte
);
    import pdt_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] len_q;
    logic [7:0] hdr_low_q;
    logic [7:0] hdr_high_q;
    logic [7:0] pay_q [PAY_BYTES];
    logic [9:0] volt_q;
    logic [1:0] scale_q;
    pdt_state_t state_q;

    function automatic logic in_payload(input logic [7:0] a);
        in_payload = (a >= OFS_PAY_FIRST) && (a <= OFS_PAY_LAST);
    endfunction : in_payload

    function automatic logic [4:0] pay_index(input logic [7:0] a);
        logic [7:0] diff;
        diff      = a - OFS_PAY_FIRST;
        pay_index = diff[4:0];
    endfunction : pay_index

    logic ctrl_wr;
    logic attempt_end;
    assign ctrl_wr     = i_reg_wr && (i_reg_addr == OFS_TX_CTRL)
                         && (state_q == PDT_IDLE);
    // a dropped request also counts as a finished attempt
    assign attempt_end = ((state_q == PDT_BUSY) && i_tx_done)
                         || (ctrl_wr && i_received_message_flag);

    // ------------------------------------------------------------
    // transmit sequencing
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q      <= PDT_IDLE;
            o_tx_start   <= 1'b0;
            o_tx_discard <= 1'b0;
        end else begin
            o_tx_start   <= ctrl_wr && !i_received_message_flag;
            o_tx_discard <= ctrl_wr && i_received_message_flag;
            case (state_q)
                PDT_IDLE: begin
                    if (ctrl_wr && !i_received_message_flag) begin
                        state_q <= PDT_BUSY;
                    end
                end
                PDT_BUSY: begin
                    if (i_tx_done) begin
                        state_q <= PDT_IDLE;
                    end
                end
                default: state_q <= PDT_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // control and length; end of attempt beats a same-cycle write
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_q <= RST_BYTE;
        end else if (attempt_end) begin
            ctrl_q <= RST_BYTE;
        end else if (ctrl_wr) begin
            ctrl_q <= i_reg_wdata & CTRL_WR_MASK;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            len_q <= RST_BYTE;
        end else if (attempt_end) begin
            len_q <= RST_BYTE;
        end else if (i_reg_wr && (i_reg_addr == OFS_TX_LEN)) begin
            len_q <= i_reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // header and payload
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hdr_low_q  <= RST_BYTE;
            hdr_high_q <= RST_BYTE;
        end else if (i_reg_wr) begin
            if (i_reg_addr == OFS_HDR_LOW) begin
                hdr_low_q <= i_reg_wdata;
            end
            if (i_reg_addr == OFS_HDR_HIGH) begin
                hdr_high_q <= i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < PAY_BYTES; i++) begin
                pay_q[i] <= RST_BYTE;
            end
        end else if (i_reg_wr && in_payload(i_reg_addr)) begin
            pay_q[pay_index(i_reg_addr)] <= i_reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // voltage capture from the same-clock converter
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            volt_q  <= RST_VOLT;
            scale_q <= RST_SCALE;
        end else begin
            volt_q  <= i_bus_voltage_reading;
            scale_q <= i_scale_code;
        end
    end

    // ------------------------------------------------------------
    // read port, one cycle behind the strobe
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= RST_BYTE;
        end else if (i_reg_rd) begin
            if (in_payload(i_reg_addr)) begin
                o_reg_rdata <= pay_q[pay_index(i_reg_addr)];
            end else begin
                case (i_reg_addr)
                    OFS_TX_CTRL:   o_reg_rdata <= ctrl_q;
                    OFS_TX_LEN:    o_reg_rdata <= len_q;
                    OFS_HDR_LOW:   o_reg_rdata <= hdr_low_q;
                    OFS_HDR_HIGH:  o_reg_rdata <= hdr_high_q;
                    OFS_VOLT_LOW:  o_reg_rdata <= volt_q[7:0];
                    OFS_VOLT_HIGH: o_reg_rdata <= {4'h0, scale_q,
                                                   volt_q[9:8]};
                    default:       o_reg_rdata <= RST_BYTE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // transmit-side view; header and payload are captured live so
    // the sender sees what was loaded before the start write
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_tx_busy           <= 1'b0;
            o_tx_frame_kind     <= PDT_KIND_SOP;
            o_tx_is_message     <= 1'b0;
            o_tx_is_ordered_set <= 1'b0;
            o_tx_is_bist        <= 1'b0;
            o_tx_retries        <= 2'h0;
            o_tx_length         <= RST_BYTE;
            o_tx_header_low     <= RST_BYTE;
            o_tx_header_high    <= RST_BYTE;
            o_tx_payload_byte   <= RST_BYTE;
        end else begin
            o_tx_busy           <= (state_q == PDT_BUSY);
            o_tx_frame_kind     <= pdt_kind_t'(ctrl_q[KIND_LSB +: 3]);
            o_tx_is_message     <= ctrl_q[KIND_LSB +: 3]
                                   <= PDT_KIND_DBG_PP;
            o_tx_is_ordered_set <= (ctrl_q[KIND_LSB +: 3]
                                    == PDT_KIND_HARD_RST)
                                   || (ctrl_q[KIND_LSB +: 3]
                                    == PDT_KIND_CABLE_RST);
            o_tx_is_bist        <= ctrl_q[KIND_LSB +: 3]
                                   == PDT_KIND_BIST;
            o_tx_retries        <= ctrl_q[RETRY_LSB +: 2];
            o_tx_length         <= len_q;
            o_tx_header_low     <= hdr_low_q;
            o_tx_header_high    <= hdr_high_q;
            o_tx_payload_byte   <= (i_tx_byte_idx < 5'(PAY_BYTES))
                                   ? pay_q[i_tx_byte_idx] : RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    sequence s_good_start;
        ctrl_wr && !i_received_message_flag;
    endsequence
    sequence s_done;
        (state_q == PDT_BUSY) && i_tx_done;
    endsequence

    a_start_pulse: assert property (s_good_start |=> o_tx_start ##1
        !o_tx_start && o_tx_busy)
        else $error("start pulse or busy wrong");
    a_drop_flagged: assert property (ctrl_wr && i_received_message_flag
        |=> !o_tx_start && o_tx_discard && ctrl_q == 8'h00 && len_q == 8'h00)
        else $error("flagged request not dropped");
    a_len_cleared: assert property (s_done |=> len_q == 8'h00)
        else $error("length not cleared");
    a_ctrl_cleared: assert property (s_done |=> ctrl_q == 8'h00
        ##1 !o_tx_busy)
        else $error("control not cleared");
    a_bit3_ignored: assert property (ctrl_q[3] == 1'b0)
        else $error("reserved bit stored");
    a_retry_out: assert property (ctrl_wr && !attempt_end
        |=> ##1 o_tx_retries == $past(i_reg_wdata[5:4], 2))
        else $error("retry field wrong");
    a_kind_class: assert property (o_tx_busy |->
        $onehot({o_tx_is_message, o_tx_is_ordered_set, o_tx_is_bist})
        && (o_tx_is_bist == (o_tx_frame_kind == PDT_KIND_BIST)))
        else $error("frame kind class wrong");
    a_volt_high: assert property (i_reg_rd && i_reg_addr == OFS_VOLT_HIGH
        |=> o_reg_rdata == {4'h0, $past(i_scale_code, 2),
                            $past(i_bus_voltage_reading[9:8], 2)})
        else $error("voltage high byte wrong");
    a_header_low: assert property (i_reg_wr && i_reg_addr == OFS_HDR_LOW
        |=> ##1 o_tx_header_low == $past(i_reg_wdata, 2))
        else $error("header low not loaded");
    a_payload_rw: assert property (i_reg_wr && in_payload(i_reg_addr)
        ##1 i_reg_rd && !i_reg_wr && i_reg_addr == $past(i_reg_addr)
        |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("payload byte not kept");
endmodule : pdt_tx_regs
`default_nettype wire

// ---- tb/pdt_phy_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pdt_phy_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic       i_start,
    input  wire logic [7:0] i_delay,
    output logic            o_done
);
    // ------------------------------------------------------------
    // attempt timer: one done pulse per start, retries included
    // ------------------------------------------------------------
    logic [7:0] cnt_q;
    logic       run_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q  <= 8'h00;
            run_q  <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                run_q <= 1'b1;
                cnt_q <= i_delay;
            end else if (run_q && cnt_q == 8'h00) begin
                run_q  <= 1'b0;
                o_done <= 1'b1;
            end else if (run_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule : pdt_phy_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pdt_pkg::*;
    logic       i_clk_sys = 1'b0, i_rst_b = 1'b0, i_reg_wr = 1'b0;
    logic       i_reg_rd = 1'b0, i_received_message_flag = 1'b0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, dly = 8'h0C;
    logic [4:0] i_tx_byte_idx = 5'h00;
    logic [9:0] i_bus_voltage_reading = 10'h000;
    logic [1:0] i_scale_code = 2'h0, o_tx_retries;
    logic       i_tx_done, o_tx_start, o_tx_discard, o_tx_busy;
    logic       o_tx_is_message, o_tx_is_ordered_set, o_tx_is_bist;
    logic [7:0] o_reg_rdata, o_tx_length, o_tx_header_low, o_tx_header_high;
    logic [7:0] o_tx_payload_byte;
    logic [7:0] vlo, vhi;
    logic [15:0] vmv;
    pdt_kind_t  o_tx_frame_kind;
    int         err_total = 0, checks_done = 0, n_st = 0, n_ds = 0, ns, nd;
    always #50 i_clk_sys = ~i_clk_sys;
    // pulses last one cycle, so count them at every falling edge
    always @(negedge i_clk_sys) begin
        if (o_tx_start === 1'b1) n_st++;
        if (o_tx_discard === 1'b1) n_ds++;
    end
    pdt_tx_regs u_pdt_tx_regs (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_received_message_flag(i_received_message_flag),
        .i_tx_done(i_tx_done), .i_tx_byte_idx(i_tx_byte_idx),
        .i_bus_voltage_reading(i_bus_voltage_reading),
        .i_scale_code(i_scale_code), .o_tx_start(o_tx_start),
        .o_tx_discard(o_tx_discard), .o_tx_busy(o_tx_busy),
        .o_tx_frame_kind(o_tx_frame_kind), .o_tx_is_message(o_tx_is_message),
        .o_tx_is_ordered_set(o_tx_is_ordered_set),
        .o_tx_is_bist(o_tx_is_bist), .o_tx_retries(o_tx_retries),
        .o_tx_length(o_tx_length), .o_tx_header_low(o_tx_header_low),
        .o_tx_header_high(o_tx_header_high),
        .o_tx_payload_byte(o_tx_payload_byte));
    pdt_phy_model u_pdt_phy_model (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_start(o_tx_start), .i_delay(dly), .o_done(i_tx_done));
    // ------------------------------------------------------------
    // compare, access and wait tasks
    // ------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask : reg_wr
    // write then read the same byte on the very next edge
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        @(negedge i_clk_sys);
        chk8(o_reg_rdata, d);
    endtask : wr_rd
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        @(negedge i_clk_sys);
        chk8(o_reg_rdata, exp);
    endtask : rd_chk
    task automatic wait_busy(input logic lvl, input int n);
        int i;
        i = 0;
        while (o_tx_busy !== lvl && i < n) begin
            @(negedge i_clk_sys);
            i++;
        end
        chk1(o_tx_busy, lvl);
    endtask : wait_busy
    task automatic finish_test;
        if (err_total == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        err_total++;
        finish_test;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        for (int a = 8'h50; a <= 8'h71; a++) rd_chk(8'(a), 8'h00);
        for (int n = 0; n < 28; n++) reg_wr(OFS_PAY_FIRST + 8'(n), 8'(n*7+1));
        for (int n = 0; n < 29; n++) begin
            if (n < 28) rd_chk(OFS_PAY_FIRST + 8'(n), 8'(n*7+1));
            @(posedge i_clk_sys);
            i_tx_byte_idx <= 5'(n);
            repeat (2) @(posedge i_clk_sys);
            @(negedge i_clk_sys);
            chk8(o_tx_payload_byte, (n < 28) ? 8'(n*7+1) : 8'h00);
        end
        wr_rd(OFS_PAY_LAST, 8'h3C);
        @(posedge i_clk_sys);
        i_bus_voltage_reading <= 10'h2A5;
        i_scale_code <= 2'h2;
        reg_wr(OFS_VOLT_LOW, 8'hFF);
        reg_wr(8'h7F, 8'hFF);
        rd_chk(OFS_VOLT_LOW, 8'hA5);
        vlo = o_reg_rdata;
        rd_chk(OFS_VOLT_HIGH, 8'h0A);
        vhi = o_reg_rdata;
        // host side scaling: code 01 doubles, 10 quadruples
        vmv = {6'h00, vhi[1:0], vlo} << vhi[3:2];
        chk16(vmv, 16'h0A94);
        rd_chk(8'h7F, 8'h00);
        for (int k = 0; k < 8; k++) begin
            dly <= 8'h0C + 8'(2*k);
            reg_wr(OFS_TX_LEN, 8'(2+4*k));
            reg_wr(OFS_HDR_LOW, 8'hA0 + 8'(k));
            reg_wr(OFS_HDR_HIGH, 8'h5C);
            ns = n_st;
            reg_wr(OFS_TX_CTRL, {2'h0, 2'(k), 1'b1, 3'(k)});
            wait_busy(1'b1, 8);
            chk8(8'(n_st - ns), 8'h01);
            chk8({5'h00, o_tx_frame_kind}, 8'(k));
            chk8({6'h00, o_tx_retries}, 8'(k % 4));
            chk1(o_tx_is_message, k < 5);
            chk1(o_tx_is_ordered_set, k == 5 || k == 6);
            chk1(o_tx_is_bist, k == 7);
            chk8(o_tx_length, 8'(2+4*k));
            chk8(o_tx_header_low, 8'hA0 + 8'(k));
            chk8(o_tx_header_high, 8'h5C);
            reg_wr(OFS_TX_CTRL, 8'h02);
            rd_chk(OFS_TX_CTRL, {2'h0, 2'(k), 1'b0, 3'(k)});
            wait_busy(1'b0, 60);
            rd_chk(OFS_TX_CTRL, 8'h00);
            rd_chk(OFS_TX_LEN, 8'h00);
            chk8(o_tx_length, 8'h00);
        end
        @(posedge i_clk_sys);
        i_received_message_flag <= 1'b1;
        reg_wr(OFS_TX_LEN, 8'h06);
        ns = n_st;
        nd = n_ds;
        reg_wr(OFS_TX_CTRL, 8'h11);
        repeat (4) @(negedge i_clk_sys);
        chk8(8'(n_ds - nd), 8'h01);
        chk8(8'(n_st - ns), 8'h00);
        chk1(o_tx_busy, 1'b0);
        rd_chk(OFS_TX_CTRL, 8'h00);
        rd_chk(OFS_TX_LEN, 8'h00);
        finish_test;
    end
endmodule : tb_top
`default_nettype wire
